// ---- src/pwm_channel_period_counter.sv ----
/*
 * period counter of one pulse-width channel, with the start-value,
 * enable-event and zero-update behaviour of the silicon.
 * assumes all inputs synchronous to clk_sys; status read is a one-cycle pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module pwm_channel_period_counter
   import pwm_period_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // channel control
   input  wire logic             chan_enable,
   input  wire logic             center_align_select,
   input  wire logic             period_init_we,
   input  wire logic [CNT_W-1:0] period_init,
   input  wire logic             period_update_we,
   input  wire logic [CNT_W-1:0] period_update_reg,
   input  wire logic             status_read,
   input  wire logic             irq_enable,
   // channel status
   output logic [CNT_W-1:0]      count_q,
   output logic                  period_end_q,
   output logic                  event_flag_q,
   output logic                  irq_q,
   output logic [CNT_W-1:0]      period_q
);
   // ************************************************************
   // state
   // ************************************************************
   cnt_state_t       state_q, state_d;    // counter phase
   logic [CNT_W-1:0] count_d;             // next count
   logic [CNT_W-1:0] period_d;            // next period
   logic             period_end_d;        // next end pulse
   logic             event_flag_d;        // next sticky event
   logic             irq_d;               // next interrupt level
   logic             en_prev_q;           // enable seen last cycle
   logic             en_rise;             // channel just enabled
   logic             at_end;              // running counter sits on the period value

   // ************************************************************
   // enable edge and period match
   // ************************************************************
   // the edge detector resets to the idle level of chan_enable, so an enable
   // held low through reset gives no false event once reset is released.
   // an enable that is already high while reset falls is seen as a fresh rise;
   // that is intended, because the channel does start a first period there.
   assign en_rise = chan_enable & ~en_prev_q;

   // match is taken against the active period, never against a pending update;
   // an update that lands in the matching cycle only counts from the next one
   assign at_end  = (state_q != ST_IDLE) && chan_enable && (count_q == period_q);

   // ************************************************************
   // next-value logic
   // ************************************************************
   // notes for the next reader:
   // - the first period runs 0..period, every later one 1..period, so the first
   //   period is one clock longer; software that times the first period must
   //   allow for that extra cycle.
   // - a period of zero can only be set by the direct load; the update path
   //   drops it silently and gives no indication that it did so.
   // - the event flag is sticky: a status read clears it, but an event in the
   //   same cycle as the read wins, so no period end can be lost.
   // - the interrupt level is built from the next flag value, so it rises in
   //   the same cycle as the flag rather than one cycle behind it.

   // next-value logic for counter, period and flags
   always_comb begin
      state_d      = state_q;
      count_d      = count_q;
      period_d     = period_q;
      period_end_d = 1'b0;
      event_flag_d = event_flag_q;
      // direct write; a zero through the update path never lands
      if (period_init_we) begin
         period_d = period_init;
      end else if (period_update_we && period_update_reg != '0) begin
         period_d = period_update_reg;
      end
      case (state_q)
         ST_IDLE: begin
            count_d = CNT_FIRST_START;
            if (chan_enable) begin
               state_d = ST_FIRST;
            end
         end
         ST_FIRST, ST_LATER: begin
            if (!chan_enable) begin
               state_d = ST_IDLE;
               count_d = CNT_FIRST_START;
            end else if (count_q == period_q) begin
               // wrap to one, not zero: later periods are a cycle shorter
               count_d      = CNT_RESTART;
               period_end_d = 1'b1;
               state_d      = ST_LATER;
            end else begin
               count_d = count_q + 16'h0001;
            end
         end
         default: begin
            state_d = ST_IDLE;
            count_d = CNT_RESET;
         end
      endcase
      // read clears; a new event in the same cycle wins
      if (status_read) begin
         event_flag_d = 1'b0;
      end
      if (period_end_d || (en_rise && center_align_select)) begin
         event_flag_d = 1'b1;
      end
      irq_d = event_flag_d & irq_enable;
   end

   // ************************************************************
   // registers
   // ************************************************************
   // only registration happens here; every output of the block leaves from one
   // of these flip-flops, so no decode glitch reaches the pins.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q      <= ST_IDLE;
         count_q      <= CNT_RESET;
         period_q     <= PERIOD_RESET;
         period_end_q <= 1'b0;
         event_flag_q <= 1'b0;
         irq_q        <= 1'b0;
         en_prev_q    <= 1'b0;
      end else begin
         state_q      <= state_d;
         count_q      <= count_d;
         period_q     <= period_d;
         period_end_q <= period_end_d;
         event_flag_q <= event_flag_d;
         irq_q        <= irq_d;
         en_prev_q    <= chan_enable;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   zero_update_a: assert property (@(posedge clk_sys) disable iff (rst)
      (period_update_we && period_update_reg == '0 && !period_init_we) |=> period_q == $past(period_q))
      else $error("zero period update was applied");
   enable_event_a: assert property (@(posedge clk_sys) disable iff (rst)
      (en_rise && center_align_select) |=> event_flag_q)
      else $error("center-aligned enable did not raise event");
   first_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && chan_enable) |=> count_q == CNT_FIRST_START)
      else $error("first period did not start at zero");
   wrap_one_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q != ST_IDLE && chan_enable && count_q == period_q) |=> count_q == CNT_RESTART && period_end_q)
      else $error("counter did not wrap to one");
   count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q != ST_IDLE && chan_enable && count_q != period_q) |=> count_q == $past(count_q) + 16'h0001)
      else $error("counter did not step by one");
   end_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
      period_end_q |-> event_flag_q)
      else $error("period end lost in status");

   // ************************************************************
   // further checks on loads, flags and disable
   // ************************************************************
   // a nonzero update without a direct load must land on the next cycle
   update_lands_a: assert property (@(posedge clk_sys) disable iff (rst)
      (period_update_we && period_update_reg != '0 && !period_init_we)
      |=> period_q == $past(period_update_reg))
      else $error("nonzero period update was not applied");

   // the direct load wins over an update in the same cycle
   init_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
      period_init_we |=> period_q == $past(period_init))
      else $error("direct period load was not applied");

   // an end of period is always followed by the wrap pulse
   end_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      at_end |=> period_end_q)
      else $error("period end pulse missing");

   // the interrupt only ever stands while the event flag does
   irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      irq_q |-> event_flag_q)
      else $error("interrupt raised without event");

   // a read with no competing event clears the flag
   read_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      (status_read && !at_end && !(en_rise && center_align_select))
      |=> !event_flag_q)
      else $error("status read did not clear event");

   // a dropped enable sends the counter back to the first-period start
   disable_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      !chan_enable |=> (count_q == CNT_FIRST_START) && (state_q == ST_IDLE))
      else $error("disabled channel did not return to idle");
endmodule
`default_nettype wire

// ---- src/pwm_period_pkg.sv ----
/*
 * constants for one pulse-width channel's period counter.
 * assumes a single 250 MHz system clock and a synchronous active-high reset.
 */
// What this block does
// - center-aligned enable raises a spurious event flag
// - first period counts from zero to period
// - later periods restart at one
// - zero written to update register is ignored
package pwm_period_pkg;
   // ************************************************************
   // widths and values
   // ************************************************************
   localparam int unsigned CNT_W          = 16;
   localparam logic [15:0] CNT_FIRST_START = 16'h0000;
   localparam logic [15:0] CNT_RESTART     = 16'h0001;
   localparam logic [15:0] PERIOD_RESET    = 16'hFFFF;
   localparam logic [15:0] CNT_RESET       = 16'h0000;

   // counter states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FIRST,
      ST_LATER
   } cnt_state_t;
endpackage

// ---- dv/pwm_channel_period_counter_bench.sv ----
/* bench for one pulse-width channel's period counter.
   assumes pwm_period_pkg is compiled first; the bench drives every input itself. */
`timescale 1ns/100ps
`default_nettype none
module pwm_channel_period_counter_bench import pwm_period_pkg::*;;
   // ******************** stimulus and status ********************
   logic             clk_sys, rst, en, ca, iwe, uwe, rd, ie; // control inputs
   logic [CNT_W-1:0] iv, uv, cnt, per;                       // period values, count
   logic             pe, ev, irq;                            // status outputs
   int               failures = 0, n_checks = 0;
   logic [15:0]      wc [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0001, 16'h0002, 16'h0001};
   pwm_channel_period_counter i_dut (.clk_sys(clk_sys), .rst(rst), .chan_enable(en), .center_align_select(ca),
      .period_init_we(iwe), .period_init(iv), .period_update_we(uwe), .period_update_reg(uv),
      .status_read(rd), .irq_enable(ie), .count_q(cnt), .period_end_q(pe), .event_flag_q(ev),
      .irq_q(irq), .period_q(per));
   // ******************** checks ********************
   task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_flag(input string nm, input logic exp, input logic got);
      chk_val(nm, {15'h0, exp}, {15'h0, got});
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ******************** scenarios ********************
   // first period counts from zero, later ones restart at one
   task automatic t_walk;
      iv = 16'h0002; iwe = 1'b1; tick(1); iwe = 1'b0; en = 1'b1;
      for (int k = 0; k < 6; k++) begin
         tick(1);
         chk_val("count", wc[k], cnt);
         chk_flag("period_end", k == 3 || k == 5, pe);
      end
      chk_flag("event", 1'b1, ev);
      en = 1'b0; tick(1);
      $display("test walk done");
   endtask
   // enabling in center mode flags an event; read it off before unmasking
   task automatic t_center;
      ca = 1'b1; iv = 16'h0100; iwe = 1'b1; rd = 1'b1; tick(1); iwe = 1'b0; rd = 1'b0; tick(1);
      chk_flag("event", 1'b0, ev);
      en = 1'b1; tick(1);
      chk_flag("event", 1'b1, ev);
      chk_flag("irq", 1'b0, irq);
      rd = 1'b1; tick(1); rd = 1'b0; ie = 1'b1; tick(1);
      chk_flag("event", 1'b0, ev);
      chk_flag("irq", 1'b0, irq);
      en = 1'b0; tick(1); en = 1'b1; tick(1);
      chk_flag("irq", 1'b1, irq);
      en = 1'b0; ca = 1'b0; ie = 1'b0; tick(1);
      $display("test center done");
   endtask
   // a zero through the update path is dropped, a nonzero one lands
   task automatic t_update;
      iv = 16'h0005; iwe = 1'b1; tick(1); iwe = 1'b0;
      uv = 16'h0000; uwe = 1'b1; tick(1); uwe = 1'b0; tick(1);
      chk_val("period", 16'h0005, per);
      uv = 16'h0003; uwe = 1'b1; tick(1); uwe = 1'b0; tick(1);
      chk_val("period", 16'h0003, per);
      iv = 16'h0007; iwe = 1'b1; uv = 16'h0009; uwe = 1'b1; tick(1); iwe = 1'b0; uwe = 1'b0; tick(1);
      chk_val("period", 16'h0007, per);
      $display("test update done");
   endtask
   // ******************** sequence ********************
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      {rst, en, ca, iwe, uwe, rd, ie} = 7'h01 << 6; iv = '0; uv = '0;
      tick(20); rst = 1'b0; tick(1);
      chk_val("count", 16'h0000, cnt); chk_val("period", 16'hFFFF, per); chk_flag("event", 1'b0, ev);
      t_walk(); t_center(); t_update();
      results();
   end
   // watchdog: the run needs well under 100 cycles after reset
   initial begin
      #4000;
      failures++;
      results();
   end
endmodule
`default_nettype wire
